// [design/ocfg_chan_decode.sv]
`timescale 1ns/100ps
`default_nettype none
module ocfg_chan_decode
(
    input wire logic [7:0] div_upper_i,  // divider bits 19:16 in low nibble
    input wire logic [7:0] div_middle_i, // divider bits 15:8
    input wire logic [7:0] div_lower_i,  // divider bits 7:0
    input wire logic [7:0] pol_str_i,    // polarity and strength byte
    input wire logic [7:0] delay_i,      // output_delay_setting byte
    input wire logic [7:0] sup_drv_i,    // supply and driver byte
    output ocfg_pkg::ocfg_chan_t cfg_o   // decoded channel settings
);
    logic [1:0] pol;
    logic [1:0] fine_code;
    logic [1:0] sup;
    logic [2:0] drv;

    // field extraction
    assign pol = pol_str_i[ocfg_pkg::POL_MSB:ocfg_pkg::POL_LSB];
    assign fine_code = delay_i[ocfg_pkg::FINE_MSB:ocfg_pkg::FINE_LSB];
    assign sup = sup_drv_i[ocfg_pkg::SUP_MSB:ocfg_pkg::SUP_LSB];
    assign drv = sup_drv_i[ocfg_pkg::DRV_MSB:0];

    // field decode into the channel struct
    always_comb
    begin
        cfg_o = '0;
        cfg_o.output_divider_value = {div_upper_i[ocfg_pkg::DIVU_MSB:0], div_middle_i,
            div_lower_i};
        case (pol)
            ocfg_pkg::POL_NORMAL:    {cfg_o.pos_inverted, cfg_o.neg_inverted} = 2'h1;
            ocfg_pkg::POL_BOTH_TRUE: {cfg_o.pos_inverted, cfg_o.neg_inverted} = 2'h0;
            ocfg_pkg::POL_BOTH_INV:  {cfg_o.pos_inverted, cfg_o.neg_inverted} = 2'h3;
            default:                 {cfg_o.pos_inverted, cfg_o.neg_inverted} = 2'h2; // swapped
        endcase
        cfg_o.strength = pol_str_i[ocfg_pkg::STR_MSB:0];
        cfg_o.coarse_delay = delay_i[ocfg_pkg::COARSE_MSB:0];
        cfg_o.fine_delay_ps = 7'(int'(fine_code) * ocfg_pkg::FINE_STEP_PS);
        case (sup)
            ocfg_pkg::SUP_1V8: cfg_o.output_supply_level = 3'h1;
            ocfg_pkg::SUP_2V5: cfg_o.output_supply_level = 3'h2;
            ocfg_pkg::SUP_3V3: cfg_o.output_supply_level = 3'h4;
            default:           cfg_o.output_supply_level = 3'h0;
        endcase
        case (drv)
            ocfg_pkg::DRV_CML:        cfg_o.driver_standard_select = 6'h01;
            ocfg_pkg::DRV_HCSL:       cfg_o.driver_standard_select = 6'h02;
            ocfg_pkg::DRV_LVDS:       cfg_o.driver_standard_select = 6'h04;
            ocfg_pkg::DRV_LVDS_BOOST: cfg_o.driver_standard_select = 6'h08;
            ocfg_pkg::DRV_PECL_CM:    cfg_o.driver_standard_select = 6'h10;
            ocfg_pkg::DRV_PECL_NOCM:  cfg_o.driver_standard_select = 6'h20;
            default:                  cfg_o.driver_standard_select = 6'h00;
        endcase
    end

endmodule
`default_nettype wire

// [design/ocfg_page.sv]
`timescale 1ns/100ps
`default_nettype none
module ocfg_page
(
    input wire logic CLK_I,                      // 125 MHz clock
    input wire logic RST_N_I,                    // synchronous reset, active low
    input wire logic CE_I,                       // clock enable, freezes all state when low
    input wire ocfg_pkg::ocfg_req_t REQ_I,       // register port request
    output logic [7:0] RDATA_O,                  // read data, valid cycle after rd
    output logic ACTIVE_O,                       // high in active state
    output logic FUSE_PROG_O,                    // one-cycle fuse program start
    output logic FUSE_READ_O,                    // one-cycle fuse readback start
    output ocfg_pkg::ocfg_chan_t CH1_CFG_O,      // output 1 decoded settings
    output logic [19:0] CH2_DIV_UPPER_O          // output 2 divider, upper nibble placed
);
    localparam int DEPTH = ocfg_pkg::SHADOW_DEPTH;

    ocfg_pkg::ocfg_state_t state_q;
    logic [7:0] page_q;
    logic [7:0] directive_q;
    logic [7:0] live_q [DEPTH];
    logic [7:0] shadow_q [DEPTH];
    logic [7:0] rdata_d;
    logic wr_page;
    logic wr_here;
    logic cmd_go;
    logic [4:0] cmd;
    logic copy_go;
    logic prog_go;
    logic read_go;
    logic active_go;
    logic escape_go;
    ocfg_pkg::ocfg_chan_t ch1_d;

    // address lies in the shadowed range
    function automatic logic in_shadow(input logic [7:0] a);
        return (a >= ocfg_pkg::ADDR_SHADOW_LO) && (a <= ocfg_pkg::ADDR_SHADOW_HI);
    endfunction

    // index of an address into the live and shadow arrays
    function automatic logic [6:0] shadow_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - ocfg_pkg::ADDR_SHADOW_LO;
        return d[6:0];
    endfunction

    // write decode and command qualification
    assign wr_page = REQ_I.wr && (REQ_I.addr == ocfg_pkg::ADDR_PAGE);
    assign wr_here = REQ_I.wr && (page_q == ocfg_pkg::PAGE_THIS);
    assign cmd = REQ_I.wdata[ocfg_pkg::CMD_MSB:ocfg_pkg::CMD_LSB];
    assign cmd_go = wr_here && (REQ_I.addr == ocfg_pkg::ADDR_DIRECTIVE)
        && (state_q == ocfg_pkg::OCFG_ST_CMD);
    assign prog_go = cmd_go && (cmd == ocfg_pkg::CMD_PROGRAM);
    assign read_go = cmd_go && (cmd == ocfg_pkg::CMD_READBACK);
    assign copy_go = cmd_go && (cmd == ocfg_pkg::CMD_COPY);
    assign active_go = cmd_go && (cmd == ocfg_pkg::CMD_ACTIVE);
    assign escape_go = wr_here && (REQ_I.addr == ocfg_pkg::ADDR_DIRECTIVE)
        && (state_q == ocfg_pkg::OCFG_ST_ACTIVE) && REQ_I.wdata[ocfg_pkg::ESC_BIT];

    // page register, reachable whatever page is selected
    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
            page_q <= ocfg_pkg::RST_PAGE;
        else if (CE_I && wr_page)
            page_q <= REQ_I.wdata;
    end

    // directive register stores every bit written, spares included
    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
            directive_q <= ocfg_pkg::RST_BYTE;
        else if (CE_I && wr_here && (REQ_I.addr == ocfg_pkg::ADDR_DIRECTIVE))
            directive_q <= REQ_I.wdata;
    end

    // command and active state machine
    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
            state_q <= ocfg_pkg::OCFG_ST_CMD;
        else if (CE_I)
        begin
            case (state_q)
                ocfg_pkg::OCFG_ST_CMD:
                    if (active_go)
                        state_q <= ocfg_pkg::OCFG_ST_ACTIVE;
                ocfg_pkg::OCFG_ST_ACTIVE:
                    if (escape_go)
                        state_q <= ocfg_pkg::OCFG_ST_CMD;
                default:
                    state_q <= ocfg_pkg::OCFG_ST_CMD;
            endcase
        end
    end

    // live settings: copy command loads all from shadow, else software writes
    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            for (int i = 0; i < DEPTH; i++)
                live_q[i] <= ocfg_pkg::RST_BYTE;
        end
        else if (CE_I)
        begin
            if (copy_go)
            begin
                for (int i = 0; i < DEPTH; i++)
                    live_q[i] <= shadow_q[i];
            end
            else if (wr_here && in_shadow(REQ_I.addr))
                live_q[shadow_idx(REQ_I.addr)] <= REQ_I.wdata;
        end
    end

    // shadow image: fuse programming burns the current live settings
    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            for (int i = 0; i < DEPTH; i++)
                shadow_q[i] <= ocfg_pkg::RST_BYTE;
        end
        else if (CE_I && prog_go)
        begin
            for (int i = 0; i < DEPTH; i++)
                shadow_q[i] <= live_q[i];
        end
    end

    // one-cycle fuse start pulses
    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            FUSE_PROG_O <= 1'b0;
            FUSE_READ_O <= 1'b0;
        end
        else if (CE_I)
        begin
            FUSE_PROG_O <= prog_go;
            FUSE_READ_O <= read_go;
        end
    end

    // read mux; page register reads on every page, other pages and unmapped offsets read zero
    always_comb
    begin
        rdata_d = 8'h00;
        if (REQ_I.addr == ocfg_pkg::ADDR_PAGE)
            rdata_d = page_q;
        else if (page_q != ocfg_pkg::PAGE_THIS)
            rdata_d = 8'h00;
        else if (REQ_I.addr == ocfg_pkg::ADDR_DIRECTIVE)
            rdata_d = directive_q;
        else if (in_shadow(REQ_I.addr))
            rdata_d = live_q[shadow_idx(REQ_I.addr)];
    end

    // registered read data
    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
            RDATA_O <= 8'h00;
        else if (CE_I && REQ_I.rd)
            RDATA_O <= rdata_d;
    end

    // decode output 1 fields from live bytes
    ocfg_chan_decode u_ch1_decode
    (
        .div_upper_i(live_q[shadow_idx(ocfg_pkg::ADDR_O1_DIV_UPPER)]),
        .div_middle_i(live_q[shadow_idx(ocfg_pkg::ADDR_O1_DIV_MIDDLE)]),
        .div_lower_i(live_q[shadow_idx(ocfg_pkg::ADDR_O1_DIV_LOWER)]),
        .pol_str_i(live_q[shadow_idx(ocfg_pkg::ADDR_O1_POL_STRENGTH)]),
        .delay_i(live_q[shadow_idx(ocfg_pkg::ADDR_O1_DELAY)]),
        .sup_drv_i(live_q[shadow_idx(ocfg_pkg::ADDR_O1_SUPPLY_DRV)]),
        .cfg_o(ch1_d)
    );

    // registered channel outputs and state flag
    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            CH1_CFG_O <= '0;
            CH2_DIV_UPPER_O <= 20'h00000;
            ACTIVE_O <= 1'b0;
        end
        else if (CE_I)
        begin
            CH1_CFG_O <= ch1_d;
            CH2_DIV_UPPER_O <= {live_q[shadow_idx(ocfg_pkg::ADDR_O2_DIV_UPPER)][3:0],
                16'h0000};
            ACTIVE_O <= (state_q == ocfg_pkg::OCFG_ST_ACTIVE);
        end
    end

    // write on this page to a given offset with the clock enabled
    sequence s_dir_write;
        CE_I && wr_here && (REQ_I.addr == ocfg_pkg::ADDR_DIRECTIVE);
    endsequence

    sequence s_proceed;
        s_dir_write ##0 (state_q == ocfg_pkg::OCFG_ST_CMD) ##0 (cmd == ocfg_pkg::CMD_ACTIVE);
    endsequence

    sequence s_escape;
        s_dir_write ##0 (state_q == ocfg_pkg::OCFG_ST_ACTIVE) ##0 REQ_I.wdata[1];
    endsequence

    a_proceed_active: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        s_proceed ##1 CE_I |=> ACTIVE_O)
        else $error("proceed command did not reach active");

    a_escape_cmd: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        s_escape |=> (state_q == ocfg_pkg::OCFG_ST_CMD))
        else $error("escape did not return to command state");

    a_active_hold: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == ocfg_pkg::OCFG_ST_ACTIVE) && !escape_go
        |=> (state_q == ocfg_pkg::OCFG_ST_ACTIVE))
        else $error("active state left without escape");

    a_prog_pulse: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        s_dir_write ##0 (state_q == ocfg_pkg::OCFG_ST_CMD) ##0 (cmd == ocfg_pkg::CMD_PROGRAM)
        |=> FUSE_PROG_O && !FUSE_READ_O)
        else $error("program command gave no program pulse");

    a_read_pulse: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        FUSE_READ_O && $past(CE_I) |-> $past(read_go) && !FUSE_PROG_O)
        else $error("readback pulse without readback command");

    a_copy_live: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (CE_I && copy_go) |=> (live_q[0] == $past(shadow_q[0]))
        && (live_q[DEPTH-1] == $past(shadow_q[DEPTH-1])))
        else $error("copy did not load live settings from shadow");

    a_page_write: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (CE_I && wr_page) |=> (page_q == $past(REQ_I.wdata)))
        else $error("page register not written");

    a_div_output: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (CE_I && wr_here && (REQ_I.addr == ocfg_pkg::ADDR_O1_DIV_LOWER)) ##1 CE_I
        |=> (CH1_CFG_O.output_divider_value[7:0] == $past(REQ_I.wdata, 2)))
        else $error("divider low byte not on output");

    a_frozen_ce: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        !CE_I |=> $stable(state_q) && $stable(page_q) && $stable(RDATA_O))
        else $error("state changed with clock enable low");

endmodule
`default_nettype wire

// [design/ocfg_pkg.sv]
package ocfg_pkg;

    // register offsets on this page
    localparam logic [7:0] ADDR_DIRECTIVE = 8'h0f;
    localparam logic [7:0] ADDR_O1_DIV_UPPER = 8'h18;
    localparam logic [7:0] ADDR_O1_DIV_MIDDLE = 8'h19;
    localparam logic [7:0] ADDR_O1_DIV_LOWER = 8'h1a;
    localparam logic [7:0] ADDR_O1_POL_STRENGTH = 8'h1b;
    localparam logic [7:0] ADDR_O1_DELAY = 8'h1c;
    localparam logic [7:0] ADDR_O1_SUPPLY_DRV = 8'h1d;
    localparam logic [7:0] ADDR_O2_DIV_UPPER = 8'h20;
    localparam logic [7:0] ADDR_PAGE = 8'hff;
    localparam logic [7:0] ADDR_SHADOW_LO = 8'h18;
    localparam logic [7:0] ADDR_SHADOW_HI = 8'h67;
    localparam int SHADOW_DEPTH = int'(ADDR_SHADOW_HI) - int'(ADDR_SHADOW_LO) + 1;

    // page served by this block and reset values
    localparam logic [7:0] PAGE_THIS = 8'h03;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_PAGE = 8'h00;

    // programming command codes
    localparam logic [4:0] CMD_PROGRAM = 5'h18;
    localparam logic [4:0] CMD_READBACK = 5'h0c;
    localparam logic [4:0] CMD_COPY = 5'h06;
    localparam logic [4:0] CMD_ACTIVE = 5'h1b;

    // field positions
    localparam int CMD_MSB = 7;
    localparam int CMD_LSB = 3;
    localparam int ESC_BIT = 1;
    localparam int DIVU_MSB = 3;
    localparam int POL_MSB = 7;
    localparam int POL_LSB = 6;
    localparam int STR_MSB = 2;
    localparam int COARSE_MSB = 5;
    localparam int FINE_MSB = 7;
    localparam int FINE_LSB = 6;
    localparam int SUP_MSB = 4;
    localparam int SUP_LSB = 3;
    localparam int DRV_MSB = 2;

    // fine delay step in picoseconds
    localparam int FINE_STEP_PS = 30;

    // polarity codes
    localparam logic [1:0] POL_NORMAL = 2'h0;
    localparam logic [1:0] POL_BOTH_TRUE = 2'h1;
    localparam logic [1:0] POL_BOTH_INV = 2'h2;
    localparam logic [1:0] POL_SWAPPED = 2'h3;

    // supply codes
    localparam logic [1:0] SUP_1V8 = 2'h0;
    localparam logic [1:0] SUP_2V5 = 2'h1;
    localparam logic [1:0] SUP_3V3 = 2'h2;

    // driver standard codes
    localparam logic [2:0] DRV_LVDS = 3'h0;
    localparam logic [2:0] DRV_PECL_CM = 3'h1;
    localparam logic [2:0] DRV_CML = 3'h2;
    localparam logic [2:0] DRV_HCSL = 3'h3;
    localparam logic [2:0] DRV_LVDS_BOOST = 3'h4;
    localparam logic [2:0] DRV_PECL_NOCM = 3'h5;

    typedef enum logic [0:0] {
        OCFG_ST_CMD = 1'b0,
        OCFG_ST_ACTIVE = 1'b1
    } ocfg_state_t;

    // register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ocfg_req_t;

    // decoded settings of one output channel
    typedef struct packed {
        logic [19:0] output_divider_value;
        logic pos_inverted;          // cmos_pin_positive takes inverted_clock_phase
        logic neg_inverted;          // cmos_pin_negative takes inverted_clock_phase
        logic [2:0] strength;
        logic [5:0] coarse_delay;    // oscillator periods
        logic [6:0] fine_delay_ps;
        logic [2:0] output_supply_level; // one-hot: 3v3, 2v5, 1v8
        logic [5:0] driver_standard_select; // one-hot: pecl_nocm, pecl_cm, boost, lvds, hcsl, cml
    } ocfg_chan_t;

endpackage

// [testbench/tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk_i;
    logic rst_n_i;
    logic ce_i;
    ocfg_pkg::ocfg_req_t req;
    logic [7:0] rdata;
    logic active;
    logic fuse_prog;
    logic fuse_read;
    ocfg_pkg::ocfg_chan_t ch1;
    logic [19:0] ch2_div;
    int fails;
    int n_tests;
    int cycles = 0;
    logic fp_seen;
    logic fr_seen;
    logic [7:0] regs [8];
    logic [1:0] pol_exp [4];
    logic [2:0] sup_exp [4];
    logic [5:0] drv_exp [8];

    localparam int LIMIT = 3000; // whole sequence needs well under 400 cycles

    ocfg_page DUT
    (
        .CLK_I(clk_i),
        .RST_N_I(rst_n_i),
        .CE_I(ce_i),
        .REQ_I(req),
        .RDATA_O(rdata),
        .ACTIVE_O(active),
        .FUSE_PROG_O(fuse_prog),
        .FUSE_READ_O(fuse_read),
        .CH1_CFG_O(ch1),
        .CH2_DIV_UPPER_O(ch2_div)
    );

    // free-running clock at 8 ns period
    initial clk_i = 1'b0;
    always #4 clk_i = ~clk_i;

    // verdict and end of run
    task automatic test_done();
        if (fails == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // compare seen against expected and count
    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one-cycle write strobe; catches the pulse outputs one cycle after it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge clk_i);
        req.wr = 1'b0;
        fp_seen = fuse_prog;
        fr_seen = fuse_read;
        @(negedge clk_i);
    endtask

    // one-cycle read strobe, data checked the cycle after
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge clk_i);
        req.rd = 1'b0;
        chk(20'(rdata), 20'(exp));
        @(negedge clk_i);
    endtask

    // directive write with expected pulses and resulting state
    task automatic cmd(input logic [7:0] d, input logic ep, input logic er, input logic ea);
        wr(ocfg_pkg::ADDR_DIRECTIVE, d);
        chk(20'({fp_seen, fr_seen}), 20'({ep, er}));
        chk(20'({fuse_prog, fuse_read}), 20'h00000);
        chk(20'(active), 20'(ea));
    endtask

    // hang guard
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            fails++;
            test_done();
        end
    end

    // main sequence
    initial
    begin
        fails = 0;
        n_tests = 0;
        req = '0;
        rst_n_i = 1'b0;
        ce_i = 1'b1;
        regs = '{8'h0f, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h20};
        pol_exp = '{2'h1, 2'h0, 2'h3, 2'h2};
        sup_exp = '{3'h1, 3'h2, 3'h4, 3'h0};
        drv_exp = '{6'h04, 6'h10, 6'h01, 6'h02, 6'h08, 6'h20, 6'h00, 6'h00};
        repeat (6) @(negedge clk_i);
        rst_n_i = 1'b1;
        // page register and page gating
        rchk(ocfg_pkg::ADDR_PAGE, 8'h00);
        wr(ocfg_pkg::ADDR_O1_DIV_MIDDLE, 8'h55);
        wr(ocfg_pkg::ADDR_PAGE, ocfg_pkg::PAGE_THIS);
        rchk(ocfg_pkg::ADDR_PAGE, ocfg_pkg::PAGE_THIS);
        for (int i = 0; i < 8; i++)
            rchk(regs[i], 8'h00);
        // divider assembly, spare nibble stored
        wr(ocfg_pkg::ADDR_O1_DIV_UPPER, 8'ha5);
        wr(ocfg_pkg::ADDR_O1_DIV_MIDDLE, 8'h3c);
        wr(ocfg_pkg::ADDR_O1_DIV_LOWER, 8'h7e);
        chk(ch1.output_divider_value, 20'h53c7e);
        rchk(ocfg_pkg::ADDR_O1_DIV_UPPER, 8'ha5);
        wr(ocfg_pkg::ADDR_O2_DIV_UPPER, 8'hf9);
        chk(ch2_div, 20'h90000);
        // polarity and strength
        for (int p = 0; p < 4; p++)
        begin
            wr(ocfg_pkg::ADDR_O1_POL_STRENGTH, {p[1:0], 3'h5, 3'h7});
            chk(20'({ch1.pos_inverted, ch1.neg_inverted}), 20'(pol_exp[p]));
            chk(20'(ch1.strength), 20'h00007);
        end
        // coarse and fine delay
        for (int i = 0; i < 8; i++)
        begin
            wr(ocfg_pkg::ADDR_O1_DELAY, {i[1:0], (i[2] ? 6'h3f : 6'h15)});
            chk(20'(ch1.coarse_delay), (i[2] ? 20'h0003f : 20'h00015));
            chk(20'(ch1.fine_delay_ps), 20'(i[1:0] * ocfg_pkg::FINE_STEP_PS));
        end
        // supply and driver codes, spare bits 7 and 5 set
        for (int i = 0; i < 8; i++)
        begin
            wr(ocfg_pkg::ADDR_O1_SUPPLY_DRV, {3'h5, i[1:0], i[2:0]});
            chk(20'(ch1.output_supply_level), 20'(sup_exp[i[1:0]]));
            chk(20'(ch1.driver_standard_select), 20'(drv_exp[i]));
        end
        // clock enable low freezes the register file
        ce_i = 1'b0;
        wr(ocfg_pkg::ADDR_O1_DIV_MIDDLE, 8'hee);
        ce_i = 1'b1;
        rchk(ocfg_pkg::ADDR_O1_DIV_MIDDLE, 8'h3c);
        // program, copy back, readback, unused code
        wr(ocfg_pkg::ADDR_SHADOW_HI, 8'haa);
        cmd({ocfg_pkg::CMD_PROGRAM, 3'h0}, 1'b1, 1'b0, 1'b0);
        wr(ocfg_pkg::ADDR_O1_DIV_MIDDLE, 8'h00);
        wr(ocfg_pkg::ADDR_SHADOW_HI, 8'h00);
        chk(ch1.output_divider_value, 20'h5007e);
        cmd({ocfg_pkg::CMD_COPY, 3'h0}, 1'b0, 1'b0, 1'b0);
        chk(ch1.output_divider_value, 20'h53c7e);
        rchk(ocfg_pkg::ADDR_SHADOW_HI, 8'haa);
        cmd({ocfg_pkg::CMD_READBACK, 3'h0}, 1'b0, 1'b1, 1'b0);
        cmd(8'hf8, 1'b0, 1'b0, 1'b0);
        rchk(ocfg_pkg::ADDR_DIRECTIVE, 8'hf8);
        wr(8'h68, 8'hbb);
        rchk(8'h68, 8'h00);
        // command state bit 1 does nothing, then active and escape
        cmd(8'h02, 1'b0, 1'b0, 1'b0);
        cmd({ocfg_pkg::CMD_ACTIVE, 3'h0}, 1'b0, 1'b0, 1'b1);
        cmd({ocfg_pkg::CMD_PROGRAM, 3'h0}, 1'b0, 1'b0, 1'b1);
        cmd(8'h02, 1'b0, 1'b0, 1'b0);
        cmd({ocfg_pkg::CMD_READBACK, 3'h0}, 1'b0, 1'b1, 1'b0);
        test_done();
    end
endmodule
`default_nettype wire
